// *** hdl/mon_i2c_map.vh ***
// constants of the monitor two-wire slave interface
`ifndef MON_I2C_MAP_VH
`define MON_I2C_MAP_VH

// ==========================================
// slave addressing
`define FIXED_ADDR_HI  3'h6
`define BCAST_ADDR     7'h66

// three-state select pin codes
`define PIN_LOW        2'h0
`define PIN_HIGH       2'h1
`define PIN_OPEN       2'h2

// ==========================================
// register map
`define REG_CTRL       3'h6
`define REG_RSVD       3'h7
`define CTRL_RST       8'h0c
`define CTRL_WMASK     8'hfc
`define DATA_LSB_MASK  8'hf0
`define BIT_TEST       4
`define BIT_PAGE_EN    3
`define BIT_TMO_EN     2

// ==========================================
// timing
`define TMO_MS         33
`define CLK_MHZ        100

`endif

// *** hdl/monitor_i2c_slave_interface.v ***
// two-wire slave interface with register pointer and stuck-bus timer
// Functional notes
// [RQ1] read/write slave: byte, word and page reads and writes
// [RQ2] pointer advances by one after every data byte read or written
// [RQ3] pointer wraps from 06h back to 00h
// [RQ4] stop condition returns pointer to 00h and ends the transfer
// [RQ5] page transfers beyond two bytes disabled when page enable bit clear
// [RQ6] master idles lines high; start and stop are data edges with clock high
// [RQ7] stuck timer runs while either line low, clears when both high
// [RQ8] lines low beyond 33 ms reset the serial state machine
// [RQ9] timeout enable bit clear disables the stuck timer
// [RQ10] address bits 6:4 are 110, 3:0 from select pins, then R/W
// [RQ11] select pin pairs map to nine low address nibbles 7h to fh
// [RQ12] broadcast write address 1100110 accepted regardless of pins
// [RQ13] device pulls data low on ninth clock to acknowledge
// [RQ14] transmitter releases data during the acknowledge pulse
// [RQ15] reading master acks for more, nacks last byte then stops
// [RQ16] master may abort with stop when slave does not acknowledge
// [RQ17] low three command bits load the register pointer
// [RQ18] write data bytes acknowledged, stored at pointer, pointer advances; data registers are stored only while the test bit is set
// [RQ19] read is write address, command, repeated start, read address
// [RQ20] read address acked, selected register sent, next on master ack
// [RQ21] split variant: separate data input, inverted open-drain output
// [RQ22] command bits seven to three ignored
// [RQ23] page enable bit resets to one
// [RQ24] timeout enable bit resets to one
// [RQ25] unmatched address not acked, device idle until next start
// [RQ26] sample on clock rise, change output only while clock low
`include "mon_i2c_map.vh"

module monitor_i2c_slave_interface #(
   parameter [31:0] TIMEOUT_CYCLES = `TMO_MS * 1000 * `CLK_MHZ
) (
   input  wire       clk,
   input  wire       sys_rst,
   input  wire       scl_in,
   input  wire       sda_in,
   output wire       sda_out,
   output reg        sda_oe_n,
   input  wire       split_variant,
   input  wire       split_data_in,
   output wire       inverted_data_out,
   output reg        inverted_data_out_oe_n,
   input  wire [1:0] addr_select_high_pin,
   input  wire [1:0] addr_select_low_pin,
   output wire [7:0] control_reg
);

   // ==========================================
   // states
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_RX   = 3'h1;
   localparam [2:0] ST_ACK  = 3'h2;
   localparam [2:0] ST_TX   = 3'h3;
   localparam [2:0] ST_RACK = 3'h4;

   localparam [1:0] K_ADDR = 2'h0;
   localparam [1:0] K_CMD  = 2'h1;
   localparam [1:0] K_DATA = 2'h2;

   localparam [21:0] TMO_LIM = TIMEOUT_CYCLES[21:0];

   // ==========================================
   // input synchronisers
   wire       sda_raw;
   reg        scl_m_q;
   reg        scl_s_q;
   reg        scl_p_q;
   reg        sda_m_q;
   reg        sda_s_q;
   reg        sda_p_q;
   reg  [3:0] adr_m_q;
   reg  [3:0] adr_s_q;

   assign sda_raw = split_variant ? split_data_in : sda_in; // [RQ21]

   always @(posedge clk) begin
      if (sys_rst) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
         adr_m_q <= 4'h0;
         adr_s_q <= 4'h0;
      end else begin
         scl_m_q <= scl_in;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= sda_raw;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
         adr_m_q <= {addr_select_high_pin, addr_select_low_pin};
         adr_s_q <= adr_m_q;
      end
   end

   wire scl_rise = scl_s_q & ~scl_p_q;
   wire scl_fall = ~scl_s_q & scl_p_q;
   wire start_ev = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q; // [RQ6]
   wire stop_ev  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q; // [RQ6]

   // ==========================================
   // address decode
   reg [3:0] addr_lo;

   always @* begin
      case (adr_s_q) // [RQ11]
         {`PIN_HIGH, `PIN_LOW}:  addr_lo = 4'h7;
         {`PIN_OPEN, `PIN_HIGH}: addr_lo = 4'h8;
         {`PIN_HIGH, `PIN_HIGH}: addr_lo = 4'h9;
         {`PIN_OPEN, `PIN_OPEN}: addr_lo = 4'ha;
         {`PIN_OPEN, `PIN_LOW}:  addr_lo = 4'hb;
         {`PIN_LOW, `PIN_HIGH}:  addr_lo = 4'hc;
         {`PIN_HIGH, `PIN_OPEN}: addr_lo = 4'hd;
         {`PIN_LOW, `PIN_OPEN}:  addr_lo = 4'he;
         default:                addr_lo = 4'hf;
      endcase
   end

   wire [6:0] own_addr = {`FIXED_ADDR_HI, addr_lo}; // [RQ10]

   // ==========================================
   // stuck-bus timer
   reg  [21:0] tmo_q;
   reg  [7:0]  regs_q [0:6];
   wire        tmo_en   = regs_q[`REG_CTRL][`BIT_TMO_EN];
   wire        line_low = ~scl_s_q | ~sda_s_q;
   wire        tmo_fire = (tmo_q == TMO_LIM);

   always @(posedge clk) begin
      if (sys_rst) begin
         tmo_q <= 22'h0;
      end else if (!tmo_en || !line_low) begin // [RQ7] [RQ9]
         tmo_q <= 22'h0;
      end else if (!tmo_fire) begin
         tmo_q <= tmo_q + 22'h1; // [RQ7]
      end
   end

   // ==========================================
   // serial engine
   reg  [2:0] st_q;
   reg  [1:0] kind_q;
   reg  [3:0] cnt_q;
   reg  [7:0] sh_q;
   reg        rw_q;
   reg        drv_q;
   reg  [2:0] ptr_q;
   reg  [1:0] nb_q;
   reg        macked_q;
   reg  [7:0] rd_val;

   wire       page_ok  = regs_q[`REG_CTRL][`BIT_PAGE_EN] | (nb_q < 2'h2); // [RQ5]
   wire [2:0] ptr_nxt  = (ptr_q >= `REG_CTRL) ? 3'h0 : ptr_q + 3'h1; // [RQ2] [RQ3]
   wire       addr_hit = (sh_q[7:1] == own_addr) ||
                         (sh_q[7:1] == `BCAST_ADDR && !sh_q[0]); // [RQ12]
   wire       wr_ok    = (ptr_q == `REG_CTRL) || regs_q[`REG_CTRL][`BIT_TEST];

   always @* begin
      if (ptr_q == `REG_RSVD) begin
         rd_val = 8'h00;
      end else if (ptr_q == `REG_CTRL) begin
         rd_val = regs_q[ptr_q] & `CTRL_WMASK;
      end else if (ptr_q[0]) begin
         rd_val = regs_q[ptr_q] & `DATA_LSB_MASK;
      end else begin
         rd_val = regs_q[ptr_q];
      end
   end

   integer i;

   always @(posedge clk) begin
      if (sys_rst) begin
         st_q     <= ST_IDLE;
         kind_q   <= K_ADDR;
         cnt_q    <= 4'h0;
         sh_q     <= 8'h00;
         rw_q     <= 1'b0;
         drv_q    <= 1'b0;
         ptr_q    <= 3'h0;
         nb_q     <= 2'h0;
         macked_q <= 1'b0;
         for (i = 0; i < 6; i = i + 1) begin
            regs_q[i] <= 8'h00;
         end
         regs_q[`REG_CTRL] <= `CTRL_RST; // [RQ23] [RQ24]
      end else if (stop_ev || tmo_fire) begin
         st_q  <= ST_IDLE; // [RQ4] [RQ8]
         drv_q <= 1'b0;
         ptr_q <= 3'h0; // [RQ4]
         nb_q  <= 2'h0;
      end else if (start_ev) begin
         st_q   <= ST_RX;
         kind_q <= K_ADDR;
         cnt_q  <= 4'h0;
         drv_q  <= 1'b0;
         nb_q   <= 2'h0;
      end else begin
         case (st_q)
            ST_RX: begin
               if (scl_rise && cnt_q != 4'h8) begin
                  sh_q  <= {sh_q[6:0], sda_s_q}; // [RQ26]
                  cnt_q <= cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == 4'h8) begin
                  case (kind_q)
                     K_ADDR: begin
                        if (addr_hit) begin
                           rw_q  <= sh_q[0]; // [RQ1]
                           drv_q <= 1'b1; // [RQ13]
                           st_q  <= ST_ACK;
                        end else begin
                           st_q <= ST_IDLE; // [RQ25]
                        end
                     end
                     K_CMD: begin
                        ptr_q <= sh_q[2:0]; // [RQ17] [RQ22]
                        drv_q <= 1'b1; // [RQ13]
                        st_q  <= ST_ACK;
                     end
                     default: begin
                        if (page_ok) begin
                           if (ptr_q != `REG_RSVD && wr_ok) begin
                              regs_q[ptr_q] <= (ptr_q == `REG_CTRL) ?
                                 (sh_q & `CTRL_WMASK) : sh_q; // [RQ18]
                           end
                           ptr_q <= ptr_nxt; // [RQ2] [RQ18]
                           if (nb_q != 2'h2) begin
                              nb_q <= nb_q + 2'h1;
                           end
                           drv_q <= 1'b1; // [RQ13]
                           st_q  <= ST_ACK;
                        end else begin
                           st_q <= ST_IDLE; // [RQ5]
                        end
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  cnt_q <= 4'h0;
                  if (kind_q == K_ADDR && rw_q) begin
                     sh_q  <= rd_val; // [RQ20]
                     drv_q <= ~rd_val[7];
                     cnt_q <= 4'h1;
                     ptr_q <= ptr_nxt; // [RQ2]
                     nb_q  <= 2'h1;
                     st_q  <= ST_TX;
                  end else begin
                     drv_q  <= 1'b0;
                     kind_q <= (kind_q == K_ADDR) ? K_CMD : K_DATA;
                     st_q   <= ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (cnt_q == 4'h8) begin
                     drv_q    <= 1'b0; // [RQ14]
                     macked_q <= 1'b0;
                     st_q     <= ST_RACK;
                  end else begin
                     sh_q  <= {sh_q[6:0], 1'b0};
                     drv_q <= ~sh_q[6]; // [RQ26]
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  if (!sda_s_q && page_ok) begin
                     macked_q <= 1'b1; // [RQ15]
                  end else begin
                     st_q <= ST_IDLE; // [RQ5]
                  end
               end else if (scl_fall && macked_q) begin
                  sh_q  <= rd_val; // [RQ20]
                  drv_q <= ~rd_val[7];
                  cnt_q <= 4'h1;
                  ptr_q <= ptr_nxt; // [RQ2] [RQ3]
                  if (nb_q != 2'h2) begin
                     nb_q <= nb_q + 2'h1;
                  end
                  st_q <= ST_TX;
               end
            end
            default: begin
               drv_q <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================
   // pin drivers
   always @(posedge clk) begin
      if (sys_rst) begin
         sda_oe_n               <= 1'b1;
         inverted_data_out_oe_n <= 1'b1;
      end else begin
         sda_oe_n               <= ~(drv_q & ~split_variant);
         inverted_data_out_oe_n <= ~(~drv_q & split_variant); // [RQ21]
      end
   end

   assign sda_out           = 1'b0;
   assign inverted_data_out = 1'b0;
   assign control_reg       = regs_q[`REG_CTRL];

endmodule // monitor_i2c_slave_interface

// *** tb/bus_master.sv ***
// two-wire bus master model driving clock and data
module bus_master (
   output logic scl,
   output logic sda_m,
   input  wire  sda
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam real Q = 31.25;
   initial begin
      scl = 1'b1;  // lines idle high
      sda_m = 1'b1;
   end
   task automatic xbit(input logic b, output logic r);
      sda_m = b;
      #Q scl = 1'b1;
      #Q r = sda;
      #Q scl = 1'b0;
      #Q;
   endtask
   task automatic start();  // data falls with clock high
      sda_m = 1'b1;
      #Q scl = 1'b1;
      #Q sda_m = 1'b0;
      #Q scl = 1'b0;
      #Q;
   endtask
   task automatic stop();  // data rises with clock high
      sda_m = 1'b0;
      #Q scl = 1'b1;
      #Q sda_m = 1'b1;
      #Q;
   endtask
   task automatic tx8(input logic [7:0] d, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
   endtask
   task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
      tx8(d, r);
      xbit(a, k);  // sender releases, reader acks for more
   endtask
endmodule  // bus_master

// *** tb/mon_i2c_chk.sv ***
// assertions on the two-wire slave interface ports
module mon_i2c_chk #(
   parameter [31:0] TIMEOUT_CYCLES = 32'd600
) (
   input wire       clk,
   input wire       sys_rst,
   input wire       scl_in,
   input wire       sda_in,
   input wire       sda_out,
   input wire       sda_oe_n,
   input wire       split_variant,
   input wire       inverted_data_out_oe_n,
   input wire [7:0] control_reg
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [31:0] low_q;
   // ===========================
   // low time of either line
   always @(posedge clk) begin
      if (sys_rst || (scl_in && sda_in)) low_q <= 32'h0;
      else if (low_q != 32'hffffffff) low_q <= low_q + 32'h1;
   end
   sequence start_s;
      scl_in && $fell(sda_in);
   endsequence
   sequence stop_s;
      scl_in && $rose(sda_in);
   endsequence
   chk_reset_ctrl: assert property (disable iff (1'b0) $fell(sys_rst) |-> control_reg == 8'h0c)
      else $error("control reset value wrong");
   chk_oe_clk_low: assert property ($changed(sda_oe_n) |-> !scl_in)
      else $error("data drive changed with clock high");
   chk_split_quiet: assert property (!$past(split_variant) |-> inverted_data_out_oe_n && !sda_out)
      else $error("split output active in combined mode");
   chk_split_hold: assert property ($past(split_variant) |-> sda_oe_n)
      else $error("combined data driven in split mode");
   chk_inv_clk_low: assert property ($changed(inverted_data_out_oe_n) && $past(split_variant) == $past(split_variant, 2) |-> !scl_in)
      else $error("split drive changed with clock high");
   chk_ack_stands: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*4])
      else $error("low drive too short");
   chk_tmo_release: assert property (control_reg[2] && low_q == TIMEOUT_CYCLES + 32'd8 |-> sda_oe_n)
      else $error("stuck bus not released");
   chk_stop_quiet: assert property (stop_s |=> sda_oe_n [*4])
      else $error("drive after stop");
   chk_start_quiet: assert property (start_s |-> sda_oe_n [*8])
      else $error("drive during address");
   chk_ctrl_clk_low: assert property ($changed(control_reg) |-> !scl_in)
      else $error("control changed with clock high");
endmodule  // mon_i2c_chk
bind monitor_i2c_slave_interface mon_i2c_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_mon_i2c_chk (
   .clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n), .split_variant(split_variant),
   .inverted_data_out_oe_n(inverted_data_out_oe_n), .control_reg(control_reg));

// *** tb/monitor_i2c_slave_interface_tb_top.sv ***
// self-checking bench of the two-wire slave interface
module monitor_i2c_slave_interface_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TMO = 600;
   localparam logic [1:0] HI [9] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1, 2'h0, 2'h0};
   localparam logic [1:0] LO [9] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0};
   logic clk = 1'b0, sys_rst = 1'b1, split_variant = 1'b0, split_q = 1'b0;
   logic [1:0] hi_pin = 2'h0, lo_pin = 2'h0;
   logic [31:0] lfsr_q = 32'd72682;
   logic scl, sda_m, sda_out, sda_oe_n, inv_out, inv_oe_n, k;
   logic [7:0] control_reg, ctrl = 8'h0c, r;
   logic [6:0] own = 7'h6f;
   // split output pin high means the device pulls the host data line low
   wire sda = sda_m & (sda_oe_n | sda_out) & (~split_q | ~(inv_oe_n | inv_out));
   int failures = 0, tests_run = 0, cyc = 0;
   int mem [8];
   always #5 clk = ~clk;
   // host view of the split output follows the strap with the registered enable
   always @(posedge clk) split_q <= split_variant;
   bus_master bm (.scl(scl), .sda_m(sda_m), .sda(sda));
   monitor_i2c_slave_interface #(.TIMEOUT_CYCLES(32'(TMO))) u_monitor_i2c_slave_interface (
      .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .split_variant(split_variant), .split_data_in(sda),
      .inverted_data_out(inv_out), .inverted_data_out_oe_n(inv_oe_n),
      .addr_select_high_pin(hi_pin), .addr_select_low_pin(lo_pin), .control_reg(control_reg));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ===========================
   // register model
   function automatic int nxt(int p);
      return (p >= 6) ? 0 : p + 1;  // wrap to 00h
   endfunction
   function automatic logic [7:0] rdm(int p);
      return (p == 6) ? ctrl : (p == 7) ? 8'h00 : 8'(mem[p]);
   endfunction
   function automatic logic [7:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q[7:0];
   endfunction
   // ===========================
   // transfers
   task automatic probe(input logic [7:0] b, input logic e);
      bm.start();
      bm.xbyte(b, 1'b1, r, k);
      chk(k, e);
      bm.stop();
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] c, input int n, input int v);
      logic [7:0] d;
      int p;
      p = c[2:0];
      bm.start();
      bm.xbyte({a, 1'b0}, 1'b1, r, k);
      bm.xbyte(c, 1'b1, r, k);
      chk(k, 1'b0);
      for (int i = 0; i < n && k === 1'b0; i++) begin
         d = (v < 0) ? (rnd() | ((p == 6) ? 8'h1c : 8'h00)) : 8'(v);
         bm.xbyte(d, 1'b1, r, k);
         chk(k, i >= 2 && !ctrl[3]);
         if (k === 1'b0 && p == 6) ctrl = d & 8'hfc;
         else if (k === 1'b0 && p < 6 && ctrl[4]) mem[p] = (p % 2) ? d & 8'hf0 : d;
         p = nxt(p);
      end
      bm.stop();
      chk(control_reg, ctrl);
   endtask
   task automatic rd(input logic [7:0] c, input int n, input logic cmd);
      int p;
      p = cmd ? c[2:0] : 0;  // pointer back at 00h after stop
      if (cmd) begin
         bm.start();
         bm.xbyte({own, 1'b0}, 1'b1, r, k);
         bm.xbyte(c, 1'b1, r, k);
      end
      bm.start();
      bm.xbyte({own, 1'b1}, 1'b1, r, k);
      chk(k, 1'b0);
      for (int i = 0; i < n; i++) begin
         bm.xbyte(8'hff, i == n - 1, r, k);
         chk(r, (i >= 2 && !ctrl[3]) ? 8'hff : rdm(p));
         p = nxt(p);
      end
      bm.stop();
   endtask
   task automatic hold();
      bm.start();
      bm.tx8({own, 1'b0}, r);
      repeat (TMO + 100) @(posedge clk);
      chk(sda_oe_n, ctrl[2]);
      bm.xbit(1'b1, k);
      bm.stop();
      probe({own, 1'b0}, 1'b0);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         failures++;
         close_out();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk(control_reg, 8'h0c);
      for (int i = 0; i < 9; i++) begin
         hi_pin <= HI[i];
         lo_pin <= LO[i];
         repeat (4) @(posedge clk);
         own = 7'h67 + 7'(i);
         probe({own, 1'b0}, 1'b0);
         probe({3'h6, 4'(i % 6), 1'b0}, 1'b1);
      end
      probe({7'h66, 1'b1}, 1'b1);
      $display("test addressing done");
      wr(7'h66, 8'h06, 1, 8'h1c);
      wr(own, 8'hfc, 8, -1);
      rd(8'h05, 9, 1'b1);
      rd(8'hff, 3, 1'b1);
      rd(8'h00, 2, 1'b0);
      $display("test page access done");
      wr(own, 8'h06, 1, 8'h14);
      wr(own, 8'h00, 4, -1);
      rd(8'h00, 3, 1'b1);
      wr(own, 8'h06, 1, 8'h1c);
      $display("test page disable done");
      @(posedge clk);
      split_variant <= 1'b1;
      repeat (4) @(posedge clk);
      wr(own, 8'h00, 2, -1);
      rd(8'h00, 2, 1'b1);
      @(posedge clk);
      split_variant <= 1'b0;
      repeat (4) @(posedge clk);
      $display("test split pins done");
      hold();
      wr(own, 8'h06, 1, 8'h18);
      hold();
      wr(own, 8'h06, 1, 8'h1c);
      $display("test stuck bus done");
      close_out();
   end
endmodule  // monitor_i2c_slave_interface_tb_top
